/* src/io_cell_pkg.sv */
/*
  Constants for the programmable I/O cell and the longline three-state buffers.
  Assumes a single clock mclk, a synchronous active-high reset, and no register bus.
*/
// Function
// - Pad input reaches fabric over two independent input paths.
// - Input storage element selectable as flip-flop or latch.
// - Flop captures rising edge, latch transparent high; inverted clocks selectable.
// - Optional early-capture latch is clocked by the output clock.
// - Early-captured data is resynchronised by the regular input element.
// - Early latch transparent low, feeding rising flop or high-transparent latch.
// - Each input element clock is individually invertible inside the cell.
// - Early latch in use defaults input delay to medium setting.
// - Output optionally inverted, driven directly or through output flop.
// - Active-high three-state control floats the driver unconditionally.
// - Output data and three-state polarities are independently selectable.
// - Global set/reset loads configured set-or-clear value; clear by default. Input element and early latch always clear.
// - Output flop loads on rising edge only with clock enable high.
// - Only the global set/reset forces the I/O flip-flops.
// - Set-or-clear choice governs initial state and global reset response.
// - Each logic cell owns two buffers driving longlines above and below.
// - Each longline has weak keepers; any active driver overrides them.
// - Wired-AND mode ties control to data; open drain pulls low only.
// - Wired-AND net reads high only when every input is high.
// - Wired OR-AND pulls low only when both inputs are low.
// - Multiplexer selection is made solely through three-state controls.
package io_cell_pkg;

  typedef enum logic [1:0] {
    BUF_STANDARD,
    BUF_WIRED_AND,
    BUF_WIRED_OR_AND
  } buf_mode_t;

  typedef enum logic [1:0] {
    DELAY_NONE,
    DELAY_MEDIUM,
    DELAY_FULL
  } in_delay_t;

  localparam logic       RESET_CLEAR   = 1'b0;
  localparam logic       CE_DEFAULT    = 1'b1;
  localparam int         DELAY_MED_CYC = 1;
  localparam int         DELAY_FUL_CYC = 2;
  localparam int         DELAY_TAPS    = 2;
  localparam logic [1:0] LINE_ABOVE    = 2'h0;
  localparam logic [1:0] LINE_BELOW    = 2'h1;

endpackage : io_cell_pkg

/* src/clock_edge_gen.sv */
/*
  Slow-clock emulation: turns a sampled clock level, optionally inverted,
  into rising-edge and level strobes on mclk.
  Assumes the level input is already synchronised to mclk.
*/
`timescale 1ns/1ps
module clock_edge_gen (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // Clock level and polarity
  input  wire logic clk_level,
  input  wire logic clk_invert,
  // Strobes
  output logic      rise,
  output logic      high
);

  logic prev_r;

  assign high = clk_level ^ clk_invert;
  assign rise = high & ~prev_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      // Start at the idle level so no false edge follows reset
      prev_r <= high;
    end else begin
      prev_r <= high;
    end
  end

endmodule : clock_edge_gen

/* src/longline_driver.sv */
/*
  One logic-cell three-state buffer in standard, wired-AND or wired OR-AND mode.
  Assumes the longline resolution (keeper, pull-up) is done by the caller.
*/
`timescale 1ns/1ps
module longline_driver (
  // Mode
  input  wire io_cell_pkg::buf_mode_t mode,
  // Buffer inputs
  input  wire logic                   data_in,
  input  wire logic                   data_in_b,
  input  wire logic                   hiz_ctl,
  // Line drive
  output logic                        drive_val,
  output logic                        drive_oe_n
);

  always_comb begin
    drive_val  = 1'b0;
    drive_oe_n = 1'b1;
    case (mode)
      io_cell_pkg::BUF_STANDARD: begin
        drive_val  = data_in;
        drive_oe_n = hiz_ctl;
      end
      io_cell_pkg::BUF_WIRED_AND: begin
        drive_val  = 1'b0;
        drive_oe_n = data_in;
      end
      // pull low only if both low
      io_cell_pkg::BUF_WIRED_OR_AND: begin
        drive_val  = 1'b0;
        drive_oe_n = data_in | data_in_b;
      end
      default: begin
        drive_val  = 1'b0;
        drive_oe_n = 1'b1;
      end
    endcase
  end

endmodule : longline_driver

/* src/io_cell_top.sv */
/*
  Programmable I/O cell with input/output storage and two longline three-state buffers.
  Input and output clocks arrive as pins and are sampled on mclk; their edges or levels act as
  enables. reset is the global set/reset. Longline levels resolved here with keepers.
*/
`timescale 1ns/1ps
module io_cell_top #(
  parameter int NUM_LINES = 2
) (
  // Clock and global set/reset
  input  wire logic                   mclk,
  input  wire logic                   reset,
  // Pad
  input  wire logic                   pad_in,
  output logic                        pad_out,
  output logic                        pad_oe_n,
  // Cell clocks (pins)
  input  wire logic                   in_clk,
  input  wire logic                   out_clk,
  // Input configuration
  input  wire logic                   in_use_latch,
  input  wire logic                   in_clk_invert,
  input  wire logic                   early_enable,
  input  wire logic                   early_clk_invert,
  input  wire logic                   delay_override,
  input  wire io_cell_pkg::in_delay_t delay_sel,
  // Input paths to fabric
  output logic                        first_in_path,
  output logic                        second_in_path,
  output io_cell_pkg::in_delay_t      delay_active,
  // Output configuration and data
  input  wire logic                   out_data,
  input  wire logic                   out_ce,
  input  wire logic                   out_ce_connected,
  input  wire logic                   out_hiz,
  input  wire logic                   out_invert,
  input  wire logic                   hiz_invert,
  input  wire logic                   out_registered,
  input  wire logic                   out_clk_invert,
  input  wire logic                   set_not_clear,
  // Longline buffers
  input  wire io_cell_pkg::buf_mode_t buf_mode     [NUM_LINES],
  input  wire logic                   buf_data     [NUM_LINES],
  input  wire logic                   buf_data_b   [NUM_LINES],
  input  wire logic                   buf_hiz      [NUM_LINES],
  input  wire logic                   line_pullup  [NUM_LINES],
  input  wire logic                   line_ext_oe  [NUM_LINES],
  input  wire logic                   line_ext_val [NUM_LINES],
  output logic                        line_level   [NUM_LINES],
  output logic                        line_contend [NUM_LINES]
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic pad_s1_r, pad_s2_r;
  logic ick_s1_r, ick_s2_r;
  logic ock_s1_r, ock_s2_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      pad_s1_r <= 1'b0;
      pad_s2_r <= 1'b0;
      ick_s1_r <= 1'b0;
      ick_s2_r <= 1'b0;
      ock_s1_r <= 1'b0;
      ock_s2_r <= 1'b0;
    end else begin
      pad_s1_r <= pad_in;
      pad_s2_r <= pad_s1_r;
      ick_s1_r <= in_clk;
      ick_s2_r <= ick_s1_r;
      ock_s1_r <= out_clk;
      ock_s2_r <= ock_s1_r;
    end
  end

  // ------------------------------------------------------------
  // Clock strobes
  // ------------------------------------------------------------
  logic in_rise, in_high, ear_rise, ear_high, out_rise, out_high_unused;

  clock_edge_gen u_in_clk (
    .mclk       (mclk),
    .reset      (reset),
    .clk_level  (ick_s2_r),
    .clk_invert (in_clk_invert),
    .rise       (in_rise),
    .high       (in_high)
  );

  clock_edge_gen u_early_clk (
    .mclk       (mclk),
    .reset      (reset),
    .clk_level  (ock_s2_r),
    .clk_invert (early_clk_invert),
    .rise       (ear_rise),
    .high       (ear_high)
  );

  clock_edge_gen u_out_clk (
    .mclk       (mclk),
    .reset      (reset),
    .clk_level  (ock_s2_r),
    .clk_invert (out_clk_invert),
    .rise       (out_rise),
    .high       (out_high_unused)
  );

  // ------------------------------------------------------------
  // Selectable input delay
  // ------------------------------------------------------------
  logic [io_cell_pkg::DELAY_TAPS-1:0] dly_r;
  logic                               pad_dly;

  // medium delay default with early latch
  always_comb begin
    if (early_enable && !delay_override) begin
      delay_active = io_cell_pkg::DELAY_MEDIUM;
    end else begin
      delay_active = delay_sel;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      dly_r <= '0;
    end else begin
      dly_r <= {dly_r[io_cell_pkg::DELAY_TAPS-2:0], pad_s2_r};
    end
  end

  always_comb begin
    case (delay_active)
      io_cell_pkg::DELAY_MEDIUM: pad_dly = dly_r[io_cell_pkg::DELAY_MED_CYC-1];
      io_cell_pkg::DELAY_FULL:   pad_dly = dly_r[io_cell_pkg::DELAY_FUL_CYC-1];
      default:                   pad_dly = pad_s2_r;
    endcase
  end

  // ------------------------------------------------------------
  // Early-capture latch
  // ------------------------------------------------------------
  logic early_q_r;
  logic stage_d;

  always_ff @(posedge mclk) begin
    if (reset) begin
      early_q_r <= io_cell_pkg::RESET_CLEAR;
    end else if (!ear_high) begin
      early_q_r <= pad_dly;
    end
  end

  assign stage_d = early_enable ? early_q_r : pad_dly;

  // ------------------------------------------------------------
  // Input storage element
  // ------------------------------------------------------------
  logic in_q_r;

  // flop on rise, latch while high
  always_ff @(posedge mclk) begin
    if (reset) begin
      in_q_r <= io_cell_pkg::RESET_CLEAR;
    end else if (in_use_latch ? in_high : in_rise) begin
      in_q_r <= stage_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      first_in_path  <= 1'b0;
      second_in_path <= 1'b0;
    end else begin
      first_in_path  <= pad_dly;
      second_in_path <= in_q_r;
    end
  end

  // ------------------------------------------------------------
  // Output path
  // ------------------------------------------------------------
  logic out_q_r, set_cfg_r, ce_eff, out_pol, hiz_eff, out_sel;

  // choice captured clocked, governs reset value
  always_ff @(posedge mclk) begin
    set_cfg_r <= set_not_clear;
  end

  assign ce_eff  = out_ce_connected ? out_ce : io_cell_pkg::CE_DEFAULT;
  assign out_pol = out_data ^ out_invert;

  // only global set/reset forces flop, to the set-or-clear choice
  always_ff @(posedge mclk) begin
    if (reset) begin
      out_q_r <= set_cfg_r ^ io_cell_pkg::RESET_CLEAR;
    end else if (out_rise && ce_eff) begin
      out_q_r <= out_pol;
    end
  end

  assign out_sel = out_registered ? out_q_r : out_pol;

  assign hiz_eff  = out_hiz ^ hiz_invert;
  assign pad_oe_n = hiz_eff;

  always_ff @(posedge mclk) begin
    if (reset) begin
      pad_out <= 1'b0;
    end else begin
      pad_out <= out_sel;
    end
  end

  // ------------------------------------------------------------
  // Longline buffers and keepers
  // ------------------------------------------------------------
  logic keep_r [NUM_LINES];

  // two buffers, lines above and below
  for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
    logic dv, doe_n, lvl;

    longline_driver u_drv (
      .mode       (buf_mode[g]),
      .data_in    (buf_data[g]),
      .data_in_b  (buf_data_b[g]),
      .hiz_ctl    (buf_hiz[g]),
      .drive_val  (dv),
      .drive_oe_n (doe_n)
    );

    always_comb begin
      if (!doe_n && line_ext_oe[g]) begin
        lvl = dv & line_ext_val[g];
      end else if (!doe_n) begin
        lvl = dv;
      end else if (line_ext_oe[g]) begin
        lvl = line_ext_val[g];
      end else if (line_pullup[g]) begin
        lvl = 1'b1;
      end else begin
        lvl = keep_r[g];
      end
    end

    always_ff @(posedge mclk) begin
      if (reset) begin
        keep_r[g] <= 1'b1;
      end else begin
        keep_r[g] <= lvl;
      end
    end

    assign line_level[g]   = lvl;
    assign line_contend[g] = !doe_n && line_ext_oe[g] && (dv != line_ext_val[g]);
  end

endmodule : io_cell_top

/* testbench/pad_board.sv */
/* Board side of the pad: what the cell sees on its pin.
   Assumes pad_oe_n low means the cell drives the pin. */
`timescale 1ns/1ps
module pad_board (
  // From the cell
  input  wire logic pad_out,
  input  wire logic pad_oe_n,
  // Board level while the cell floats
  input  wire logic board_val,
  // To the cell
  output logic      pad_in
);
  assign pad_in = pad_oe_n ? board_val : pad_out;
endmodule : pad_board

/* testbench/io_cell_asserts.sv */
/* Port checker for the I/O cell.
   Bound to io_cell_top; sees only its ports. */
`timescale 1ns/1ps
module io_cell_asserts #(
  parameter int NUM_LINES = 2
) (
  // Clock and reset
  input wire logic                   mclk,
  input wire logic                   reset,
  // Output side
  input wire logic                   out_clk,
  input wire logic                   out_data,
  input wire logic                   out_hiz,
  input wire logic                   hiz_invert,
  input wire logic                   out_invert,
  input wire logic                   out_registered,
  input wire logic                   out_clk_invert,
  input wire logic                   set_not_clear,
  input wire logic                   pad_out,
  input wire logic                   pad_oe_n,
  // Input side
  input wire logic                   early_enable,
  input wire logic                   delay_override,
  input wire io_cell_pkg::in_delay_t delay_active,
  input wire logic                   first_in_path,
  input wire logic                   second_in_path,
  // Longlines
  input wire io_cell_pkg::buf_mode_t buf_mode    [NUM_LINES],
  input wire logic                   buf_data    [NUM_LINES],
  input wire logic                   buf_data_b  [NUM_LINES],
  input wire logic                   buf_hiz     [NUM_LINES],
  input wire logic                   line_ext_oe [NUM_LINES],
  input wire logic                   line_level  [NUM_LINES]
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Cycles since the output clock or output setup last moved
  logic [2:0] quiet_r;
  always_ff @(posedge mclk) begin
    if (reset || $changed({out_clk, out_invert, out_registered, out_clk_invert, set_not_clear}))
      quiet_r <= 3'h0;
    else if (quiet_r != 3'h7)
      quiet_r <= quiet_r + 3'h1;
  end
  float_ctl_a: assert property (pad_oe_n == (out_hiz ^ hiz_invert))
    else $error("pad enable does not follow float control");
  med_delay_a: assert property (early_enable && !delay_override
    |-> delay_active == io_cell_pkg::DELAY_MEDIUM) else $error("delay not medium");
  reset_clr_a: assert property (disable iff (1'b0) reset && $past(reset)
    |-> !pad_out && !first_in_path && !second_in_path) else $error("outputs set in reset");
  out_hold_a: assert property (out_registered && quiet_r >= 3'h6 |-> $stable(pad_out))
    else $error("output flop moved without clock edge");
  out_direct_a: assert property (!out_registered && $past(!out_registered)
    && !$past(reset) |-> pad_out == $past(out_data ^ out_invert)) else $error("direct out");
  std_buf_a: assert property (buf_mode[0] == io_cell_pkg::BUF_STANDARD && !buf_hiz[0]
    && !line_ext_oe[0] |-> line_level[0] == buf_data[0]) else $error("standard buffer");
  wand_low_a: assert property (buf_mode[0] == io_cell_pkg::BUF_WIRED_AND && !buf_data[0]
    |-> !line_level[0]) else $error("wired-AND not low");
  worand_low_a: assert property (buf_mode[0] == io_cell_pkg::BUF_WIRED_OR_AND
    && !buf_data[0] && !buf_data_b[0] |-> !line_level[0]) else $error("OR-AND not low");
endmodule : io_cell_asserts
bind io_cell_top io_cell_asserts #(.NUM_LINES(NUM_LINES)) chk_u (.*);

/* testbench/tb.sv */
/* Self-checking bench for io_cell_top with a board pad model.
   Assumes the checker is bound to io_cell_top. */
`timescale 1ns/1ps
module tb;
  logic mclk = 0, reset = 1, pad_in, pad_out, pad_oe_n, in_clk = 0, out_clk = 0;
  logic in_use_latch = 0, in_clk_invert = 0, early_enable = 0, early_clk_invert = 0;
  logic delay_override = 1, first_in_path, second_in_path, board_val = 0;
  logic out_data = 0, out_ce = 1, out_ce_connected = 1, out_hiz = 0, hiz_invert = 0;
  logic out_invert = 0, out_registered = 1, out_clk_invert = 0, set_not_clear = 0;
  io_cell_pkg::in_delay_t delay_sel = io_cell_pkg::DELAY_NONE, delay_active;
  io_cell_pkg::buf_mode_t buf_mode [2] = '{io_cell_pkg::BUF_STANDARD, io_cell_pkg::BUF_STANDARD};
  logic buf_data [2] = '{0, 0}, buf_data_b [2] = '{0, 0}, buf_hiz [2] = '{0, 0};
  logic line_pullup [2] = '{0, 0}, line_ext_oe [2] = '{0, 0}, line_ext_val [2] = '{0, 0};
  logic line_level [2], line_contend [2];
  int   bad_count = 0, cmp_count = 0;
  io_cell_top #(.NUM_LINES(2)) dut_u (.*);
  pad_board board_u (.*);
  always #4 mclk = ~mclk;
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  task automatic t_reset_val;
    for (int s = 1; s >= 0; s--) begin
      set_not_clear = s[0];
      reset = 1;
      cyc(4);
      reset = 0;
      cyc(3);
      chk(pad_out, s[0]);
    end
  endtask : t_reset_val
  task automatic t_hiz;
    for (int i = 0; i < 4; i++) begin
      {out_hiz, hiz_invert} = i[1:0];
      cyc(1);
      chk(pad_oe_n, i[1] ^ i[0]);
    end
  endtask : t_hiz
  task automatic t_in;
    out_hiz = 1; hiz_invert = 0; board_val = 1;
    cyc(4);
    in_clk = 1;
    cyc(8);
    chk(first_in_path, 1);
    chk(second_in_path, 1);
    board_val = 0;
    cyc(8);
    chk(second_in_path, 1);
    in_use_latch = 1;
    cyc(8);
    chk(second_in_path, 0);
    in_clk = 0; board_val = 1;
    cyc(8);
    chk(second_in_path, 0);
    in_clk_invert = 1;
    cyc(8);
    chk(second_in_path, 1);
    early_enable = 1; delay_override = 0;
    cyc(8);
    chk(delay_active, io_cell_pkg::DELAY_MEDIUM);
    out_clk = 1; board_val = 0;
    cyc(8);
    chk(second_in_path, 1);
    out_clk = 0;
    cyc(8);
    chk(second_in_path, 0);
    early_clk_invert = 1; board_val = 1;
    cyc(8);
    chk(second_in_path, 0);
    delay_override = 1; delay_sel = io_cell_pkg::DELAY_FULL;
    cyc(1);
    chk(delay_active, io_cell_pkg::DELAY_FULL);
  endtask : t_in
  task automatic t_out;
    out_hiz = 0; out_data = 1; out_clk = 1;
    cyc(6);
    chk(pad_out, 1);
    out_clk = 0; out_ce = 0; out_data = 0;
    cyc(6);
    out_clk = 1;
    cyc(6);
    chk(pad_out, 1);
    out_ce_connected = 0; out_clk = 0;
    cyc(6);
    out_clk = 1;
    cyc(6);
    chk(pad_out, 0);
    out_invert = 1; out_clk = 0;
    cyc(6);
    chk(pad_out, 0);
    out_clk = 1;
    cyc(6);
    chk(pad_out, 1);
    out_registered = 0; out_data = 1;
    cyc(3);
    chk(pad_out, 0);
  endtask : t_out
  task automatic t_lines;
    for (int i = 0; i < 2; i++) begin
      buf_hiz[i] = 0; buf_data[i] = 1;
      cyc(1);
      chk(line_level[i], 1);
      buf_data[i] = 0;
      cyc(1);
      buf_hiz[i] = 1;
      cyc(2);
      chk(line_level[i], 0);
      line_pullup[i] = 1;
      cyc(2);
      chk(line_level[i], 1);
      buf_hiz[i] = 0; buf_data[i] = 1; line_ext_oe[i] = 1;
      cyc(1);
      chk({line_level[i], line_contend[i]}, 2'b01);
      line_ext_oe[i] = 0; buf_mode[i] = io_cell_pkg::BUF_WIRED_AND;
      for (int d = 0; d < 2; d++) begin
        buf_data[i] = d[0];
        cyc(1);
        chk(line_level[i], d[0]);
      end
      buf_mode[i] = io_cell_pkg::BUF_WIRED_OR_AND;
      for (int k = 0; k < 4; k++) begin
        {buf_data[i], buf_data_b[i]} = k[1:0];
        cyc(1);
        chk(line_level[i], k != 0);
      end
    end
  endtask : t_lines
  initial begin
    cyc(4);
    reset = 0;
    t_reset_val();
    t_hiz();
    t_in();
    t_out();
    t_lines();
    finish_test();
  end
  initial begin
    #20000;
    bad_count++;
    finish_test();
  end
endmodule : tb
